/* File: design/csss_debounce.sv */
`timescale 1ns/1ps
module csss_debounce
   import csss_pkg::*;
#(
   parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Control and level.
   input wire logic restart,
   input wire logic level_in,
   output logic level_out,
   output logic settled
);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(DEB_CYC - 1);
   logic cand_r;
   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cand_r <= 1'b0;
         cnt_r <= '0;
         level_out <= 1'b0;
         settled <= 1'b0;
      end else if (restart || level_in != cand_r) begin
         cand_r <= level_in;
         cnt_r <= '0;
         settled <= 1'b0;
      end else if (cnt_r == LAST) begin
         level_out <= cand_r;
         settled <= 1'b1;
      end else begin
         cnt_r <= cnt_r + CNT_W'(1);
      end
   end
endmodule

/* File: design/csss_pin_sync.sv */
`timescale 1ns/1ps
module csss_pin_sync #(
   parameter int unsigned W = 4,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Raw pins in, settled levels out.
   csss_pins_if.sync pins
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // A level is accepted only once two stages agree, so a pin caught
   // mid-transition never reaches the sequencer.
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk) begin
         if (!rstn) begin
            s1_r[i] <= RST[i];
            s2_r[i] <= RST[i];
            s3_r[i] <= RST[i];
            pins.clean[i] <= RST[i];
         end else begin
            s1_r[i] <= pins.raw[i];
            s2_r[i] <= s1_r[i];
            s3_r[i] <= s2_r[i];
            if (s2_r[i] == s3_r[i]) begin
               pins.clean[i] <= s3_r[i];
            end
         end
      end
   end
endmodule

/* File: design/csss_pins_if.sv */
`timescale 1ns/1ps
interface csss_pins_if #(parameter int unsigned W = 4);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

/* File: design/csss_pkg.sv */
package csss_pkg;

   // Clock and sequencing times.
   localparam int unsigned SYS_CLK_MHZ = 200;
   localparam int unsigned SEQ_UNIT_NS = 25000;
   localparam int unsigned PWRUP_DELAY_NS = 220000;
   localparam int unsigned DEBOUNCE_MS = 8;
   localparam int unsigned SEQ_UNIT_CYC = (SEQ_UNIT_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int unsigned PWRUP_CYC = (PWRUP_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * SYS_CLK_MHZ;
   localparam int unsigned ACT_UNITS = 7;
   localparam int unsigned DEACT_UNITS = 2;
   localparam int unsigned CNT_W = 24;

   // Pin vector layout and its reset picture (session idle, selects low).
   localparam int unsigned NPINS = 4;
   localparam int unsigned PIN_SESSION_N = 0;
   localparam int unsigned PIN_LOW_V = 1;
   localparam int unsigned PIN_HIGH_MID = 2;
   localparam int unsigned PIN_PRESENT = 3;
   localparam logic [3:0] PIN_RST = 4'h1;

   // Register byte offsets.
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
   localparam logic [3:0] ADDR_CTRL = 4'hC;

   // Status register fields.
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_VCC_LSB = 8;
   localparam int unsigned ST_CARD_PRESENT_SWITCH_BIT = 12;
   localparam int unsigned ST_SETTLED_BIT = 13;
   localparam int unsigned ST_OK_BIT = 14;
   localparam int unsigned ST_PINS_LSB = 16;

   // Interrupt bits.
   localparam int unsigned IRQ_W = 6;
   localparam int unsigned IRQ_ACTIVE = 0;
   localparam int unsigned IRQ_DEACT_DONE = 1;
   localparam int unsigned IRQ_STOP_ENTER = 2;
   localparam int unsigned IRQ_STOP_EXIT = 3;
   localparam int unsigned IRQ_CARD_PRESENT_SWITCH_CHG = 4;
   localparam int unsigned IRQ_FAULT = 5;
   localparam logic [5:0] IRQ_MASK_RST = 6'h00;
   localparam int unsigned CTRL_FAULT_BIT = 0;
   localparam logic CTRL_FAULT_RST = 1'b0;

   typedef enum logic [5:0] {
      ST_INACTIVE = 6'h01,
      ST_ACTIVATING = 6'h02,
      ST_ACTIVE = 6'h04,
      ST_DEACT = 6'h08,
      ST_STOP = 6'h10,
      ST_WAKE = 6'h20
   } csss_state_type;

   typedef enum logic [1:0] {
      VCC_1V8 = 2'h1,
      VCC_3V0 = 2'h2,
      VCC_5V0 = 2'h3
   } csss_vcc_type;

endpackage

/* File: design/csss_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - Stop mode is entered when session request, low-voltage select and high/mid select are all high.
// - Stop mode is entered only from the inactive state, never during a session.
// - In stop mode the presence output copies the card-present switch level.
// - Stop mode ends as soon as any of the three control inputs goes low.
// - After stop mode the presence output stays low until power-up delay and debounce both expire.
// - A running deactivation always completes before stop mode can be entered.
// - The low-voltage select outranks the high/mid select when choosing the supply.
// - Low-voltage select high gives 1.8V, otherwise high/mid high gives 5V and low gives 3V.
// - Exactly three supply levels exist: 1.8V, 3V and 5V.
// - Session request returning high runs a deactivation back to the inactive state.
// - In the inactive state the presence output is low without a card and high with one.
module csss_top
   import csss_pkg::*;
#(
   parameter int unsigned UNIT_CYC = SEQ_UNIT_CYC,
   parameter int unsigned PWR_CYC = PWRUP_CYC,
   parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Avalon-MM slave.
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Host control pins.
   input wire logic card_session_request_n,
   input wire logic low_voltage_select,
   input wire logic high_mid_voltage_select,
   input wire logic card_present_switch,
   // Card side and status.
   output logic presence_ok,
   output logic vcc_enable,
   output logic [1:0] vcc_level,
   output logic card_active,
   output logic stop_mode,
   output logic irq
);
   localparam logic [CNT_W-1:0] ACT_LAST = CNT_W'(ACT_UNITS * UNIT_CYC - 1);
   localparam logic [CNT_W-1:0] DEACT_LAST = CNT_W'(DEACT_UNITS * UNIT_CYC - 1);
   localparam logic [CNT_W-1:0] PWR_LAST = CNT_W'(PWR_CYC - 1);

   function automatic csss_vcc_type vcc_decode(input logic low_v, input logic high_mid);
      if (low_v) begin
         return VCC_1V8;
      end
      return high_mid ? VCC_5V0 : VCC_3V0;
   endfunction

   function automatic logic enters(input csss_state_type cur, input csss_state_type nxt,
                                   input csss_state_type s);
      return (nxt == s) && (cur != s);
   endfunction

   csss_pins_if #(.W(NPINS)) pin_bus ();
   logic session_n;
   logic low_v;
   logic high_mid;
   logic card_present_switch_now;
   logic card_present_switch_stable;
   logic card_present_switch_settled;
   logic card_present_switch_prev_r;
   logic stop_combo;
   logic fault;
   logic in_session;
   logic fault_seen_r;
   logic pwr_done_r;
   logic deb_restart;
   csss_state_type state_r;
   csss_state_type state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic ctrl_fault_r;
   logic [31:0] rd_nxt;
   logic bus_req;
   logic bus_take;

   assign pin_bus.raw[PIN_SESSION_N] = card_session_request_n;
   assign pin_bus.raw[PIN_LOW_V] = low_voltage_select;
   assign pin_bus.raw[PIN_HIGH_MID] = high_mid_voltage_select;
   assign pin_bus.raw[PIN_PRESENT] = card_present_switch;

   csss_pin_sync #(.W(NPINS), .RST(PIN_RST)) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pins(pin_bus.sync)
   );

   assign session_n = pin_bus.clean[PIN_SESSION_N];
   assign low_v = pin_bus.clean[PIN_LOW_V];
   assign high_mid = pin_bus.clean[PIN_HIGH_MID];
   assign card_present_switch_now = pin_bus.clean[PIN_PRESENT];
   assign stop_combo = session_n & low_v & high_mid;
   assign in_session = (state_r == ST_ACTIVATING) || (state_r == ST_ACTIVE);
   // Card removal acts on the first edge, without waiting for debounce.
   assign fault = !card_present_switch_now || ctrl_fault_r;
   assign deb_restart = enters(state_r, state_nxt, ST_WAKE);

   csss_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .restart(deb_restart),
      .level_in(card_present_switch_now),
      .level_out(card_present_switch_stable),
      .settled(card_present_switch_settled)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_INACTIVE: begin
            if (stop_combo) begin
               state_nxt = ST_STOP;
            end else if (!session_n && card_present_switch_stable && card_present_switch_settled) begin
               state_nxt = ST_ACTIVATING;
            end
         end
         ST_ACTIVATING: begin
            if (session_n || fault) begin
               state_nxt = ST_DEACT;
            end else if (cnt_r == ACT_LAST) begin
               state_nxt = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (session_n || fault) begin
               state_nxt = ST_DEACT;
            end
         end
         ST_DEACT: begin
            if (cnt_r == DEACT_LAST) begin
               state_nxt = ST_INACTIVE;
            end
         end
         ST_STOP: begin
            if (!stop_combo) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (pwr_done_r && card_present_switch_settled) begin
               state_nxt = ST_INACTIVE;
            end
         end
         default: begin
            state_nxt = ST_INACTIVE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_r <= ST_INACTIVE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // One counter times activation, deactivation and the power-up delay.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cnt_r <= '0;
         pwr_done_r <= 1'b0;
      end else if (state_nxt != state_r) begin
         cnt_r <= '0;
         pwr_done_r <= 1'b0;
      end else if (state_r == ST_WAKE && cnt_r == PWR_LAST) begin
         pwr_done_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         fault_seen_r <= 1'b0;
      end else if (state_r == ST_INACTIVE) begin
         fault_seen_r <= 1'b0;
      end else if (in_session && fault) begin
         fault_seen_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         presence_ok <= 1'b0;
      end else begin
         case (state_nxt)
            ST_STOP: presence_ok <= card_present_switch_now;
            ST_WAKE: presence_ok <= 1'b0;
            ST_INACTIVE: presence_ok <= card_present_switch_stable && card_present_switch_settled;
            default: presence_ok <= !(fault_seen_r || fault);
         endcase
      end
   end

   // The selection is shown at all times; the supply runs only in session.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         vcc_level <= VCC_3V0;
         vcc_enable <= 1'b0;
         card_active <= 1'b0;
         stop_mode <= 1'b0;
      end else begin
         vcc_level <= vcc_decode(low_v, high_mid);
         vcc_enable <= (state_nxt == ST_ACTIVATING) || (state_nxt == ST_ACTIVE);
         card_active <= state_nxt == ST_ACTIVE;
         stop_mode <= state_nxt == ST_STOP;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         card_present_switch_prev_r <= 1'b0;
      end else begin
         card_present_switch_prev_r <= card_present_switch_stable;
      end
   end

   always_comb begin
      ev = '0;
      ev[IRQ_ACTIVE] = enters(state_r, state_nxt, ST_ACTIVE);
      ev[IRQ_DEACT_DONE] = (state_r == ST_DEACT) && (state_nxt == ST_INACTIVE);
      ev[IRQ_STOP_ENTER] = enters(state_r, state_nxt, ST_STOP);
      ev[IRQ_STOP_EXIT] = deb_restart;
      ev[IRQ_CARD_PRESENT_SWITCH_CHG] = card_present_switch_prev_r != card_present_switch_stable;
      ev[IRQ_FAULT] = in_session && fault && !fault_seen_r;
   end

   // A request is answered one cycle after it appears; bus_take is the
   // edge at which the master sees waitrequest low.
   assign bus_req = avs_read || avs_write;
   assign bus_take = bus_req && !avs_waitrequest;

   always_comb begin
      rd_nxt = '0;
      case (avs_address)
         ADDR_STATUS: begin
            rd_nxt[ST_STATE_LSB +: 6] = state_r;
            rd_nxt[ST_VCC_LSB +: 2] = vcc_level;
            rd_nxt[ST_CARD_PRESENT_SWITCH_BIT] = card_present_switch_stable;
            rd_nxt[ST_SETTLED_BIT] = card_present_switch_settled;
            rd_nxt[ST_OK_BIT] = presence_ok;
            rd_nxt[ST_PINS_LSB +: NPINS] = pin_bus.clean;
         end
         ADDR_IRQ_STATUS: rd_nxt[IRQ_W-1:0] = irq_stat_r;
         ADDR_IRQ_MASK: rd_nxt[IRQ_W-1:0] = irq_mask_r;
         ADDR_CTRL: rd_nxt[CTRL_FAULT_BIT] = ctrl_fault_r;
         default: rd_nxt = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else if (bus_take) begin
         avs_waitrequest <= 1'b1;
      end else if (bus_req) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? rd_nxt : '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         irq_mask_r <= IRQ_MASK_RST;
         ctrl_fault_r <= CTRL_FAULT_RST;
      end else if (bus_take && avs_write && avs_byteenable[0]) begin
         if (avs_address == ADDR_IRQ_MASK) begin
            irq_mask_r <= avs_writedata[IRQ_W-1:0];
         end
         if (avs_address == ADDR_CTRL) begin
            ctrl_fault_r <= avs_writedata[CTRL_FAULT_BIT];
         end
      end
   end

   // Only the bits actually returned are cleared, and a new event in the
   // same cycle still sets its bit.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         irq_stat_r <= '0;
         irq <= 1'b0;
      end else begin
         if (bus_take && avs_read && avs_address == ADDR_IRQ_STATUS) begin
            irq_stat_r <= (irq_stat_r & ~avs_readdata[IRQ_W-1:0]) | ev;
         end else begin
            irq_stat_r <= irq_stat_r | ev;
         end
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

endmodule

/* File: test/csss_host_model.sv */
`timescale 1ns/1ps
module csss_host_model #(
   parameter int unsigned GAP_CYC = 20
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Wanted pin levels.
   input wire logic want_session,
   input wire logic want_low,
   input wire logic want_high,
   // Pins to the device.
   output logic card_session_request_n,
   output logic low_voltage_select,
   output logic high_mid_voltage_select,
   output logic host_idle
);
   logic [7:0] gap_r;
   assign host_idle = (gap_r == 8'h00) && (low_voltage_select == want_low) &&
      (high_mid_voltage_select == want_high);
   always_ff @(posedge sys_clk) begin
      if (!rstn)
         card_session_request_n <= 1'b1;
      else
         card_session_request_n <= !want_session;
   end
   // One select at a time.
   // A falling high/mid select goes first, so a range change never passes through both high.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         low_voltage_select <= 1'b0;
         high_mid_voltage_select <= 1'b0;
         gap_r <= 8'h00;
      end else if (gap_r != 8'h00) begin
         gap_r <= gap_r - 8'h01;
      end else if (high_mid_voltage_select && !want_high) begin
         high_mid_voltage_select <= 1'b0;
         gap_r <= 8'(GAP_CYC);
      end else if (low_voltage_select != want_low) begin
         low_voltage_select <= want_low;
         gap_r <= 8'(GAP_CYC);
      end else if (high_mid_voltage_select != want_high) begin
         high_mid_voltage_select <= want_high;
         gap_r <= 8'(GAP_CYC);
      end
   end
endmodule

/* File: test/csss_monitor.sv */
`timescale 1ns/1ps
module csss_monitor
   import csss_pkg::*;
#(
   parameter int unsigned UNIT_CYC = 4,
   parameter int unsigned PWR_CYC = 20,
   parameter int unsigned DEB_CYC = 30
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Bus handshake.
   input wire logic avs_read,
   input wire logic avs_waitrequest,
   // Pins and outputs.
   input wire logic card_session_request_n,
   input wire logic low_voltage_select,
   input wire logic high_mid_voltage_select,
   input wire logic card_present_switch,
   input wire logic presence_ok,
   input wire logic vcc_enable,
   input wire logic [1:0] vcc_level,
   input wire logic card_active,
   input wire logic stop_mode
);
   localparam int WAKE_MIN = ((PWR_CYC > DEB_CYC) ? PWR_CYC : DEB_CYC) - 2;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic all_high;
   logic [15:0] idle_cnt_r;
   logic [15:0] wake_cnt_r;
   assign all_high = card_session_request_n & low_voltage_select & high_mid_voltage_select;
   always_ff @(posedge sys_clk) begin
      if (!rstn || vcc_enable)
         idle_cnt_r <= 16'h0000;
      else if (idle_cnt_r != 16'hFFFF)
         idle_cnt_r <= idle_cnt_r + 16'h0001;
   end
   // Saturated after reset so that a plain power-up is never mistaken for a wake.
   always_ff @(posedge sys_clk) begin
      if (!rstn)
         wake_cnt_r <= 16'hFFFF;
      else if ($fell(stop_mode))
         wake_cnt_r <= 16'h0000;
      else if (wake_cnt_r != 16'hFFFF)
         wake_cnt_r <= wake_cnt_r + 16'h0001;
   end
   sequence sel_steady;
      $stable(low_voltage_select) && $stable(high_mid_voltage_select);
   endsequence
   sequence stop_steady;
      stop_mode && $stable(card_present_switch);
   endsequence
   a_stop_entry: assert property ($rose(stop_mode) |-> $past(all_high) && $past(all_high, 3))
      else $error("stop mode entered without all three pins high");
   a_stop_after_deact: assert property ($rose(stop_mode) |-> idle_cnt_r >= 2 * UNIT_CYC)
      else $error("stop mode entered too soon after a session");
   a_stop_presence: assert property (stop_steady [*8] |-> presence_ok == card_present_switch)
      else $error("presence output does not follow the switch in stop mode");
   a_stop_exit: assert property ((!all_high) [*8] |-> !stop_mode)
      else $error("stop mode held with a control pin low");
   a_wake_hold: assert property (presence_ok |-> int'(wake_cnt_r) >= WAKE_MIN)
      else $error("presence output raised before the wake delays ran out");
   a_vcc_select: assert property (sel_steady [*8] |-> vcc_level == (low_voltage_select ? 2'h1 :
      (high_mid_voltage_select ? 2'h3 : 2'h2)))
      else $error("supply level does not match the select pins");
   a_vcc_legal: assert property (vcc_level inside {VCC_1V8, VCC_3V0, VCC_5V0})
      else $error("supply level code outside the three levels");
   a_session_end: assert property (card_session_request_n [*8] |-> !card_active && !vcc_enable)
      else $error("card still powered with the session request released");
   a_idle_nocard: assert property ((!card_present_switch && card_session_request_n) [*8]
      |-> !presence_ok)
      else $error("presence reported with no card outside a session");
   a_bus_answer: assert property ($rose(avs_read) && avs_waitrequest |=> !avs_waitrequest)
      else $error("read not answered after one wait cycle");
   a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
endmodule
bind csss_top csss_monitor #(.UNIT_CYC(UNIT_CYC), .PWR_CYC(PWR_CYC), .DEB_CYC(DEB_CYC)) u_mon (
   .sys_clk(sys_clk), .rstn(rstn), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
   .card_session_request_n(card_session_request_n), .low_voltage_select(low_voltage_select),
   .high_mid_voltage_select(high_mid_voltage_select), .card_present_switch(card_present_switch),
   .presence_ok(presence_ok), .vcc_enable(vcc_enable), .vcc_level(vcc_level),
   .card_active(card_active), .stop_mode(stop_mode));

/* File: test/csss_top_tb.sv */
`timescale 1ns/1ps
module csss_top_tb;
   import csss_pkg::*;
   localparam int unsigned PWR = 20;
   localparam int unsigned DEB = 30;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, presence_ok, vcc_enable, card_active, stop_mode, irq;
   logic want_session = 1'b0, want_low = 1'b0, want_high = 1'b0;
   logic card_present_switch = 1'b0;
   logic sess_n, low_v, high_mv, host_idle;
   logic [1:0] vcc_level, sel;
   logic [16:0] lfsr = 17'h106C5;
   int n_fail = 0;
   int comparisons = 0;
   csss_top #(.UNIT_CYC(4), .PWR_CYC(PWR), .DEB_CYC(DEB)) dut (.sys_clk(sys_clk), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .card_session_request_n(sess_n), .low_voltage_select(low_v),
      .high_mid_voltage_select(high_mv), .card_present_switch(card_present_switch),
      .presence_ok(presence_ok), .vcc_enable(vcc_enable), .vcc_level(vcc_level),
      .card_active(card_active), .stop_mode(stop_mode), .irq(irq));
   csss_host_model host (.sys_clk(sys_clk), .rstn(rstn), .want_session(want_session),
      .want_low(want_low), .want_high(want_high), .card_session_request_n(sess_n),
      .low_voltage_select(low_v), .high_mid_voltage_select(high_mv), .host_idle(host_idle));
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   function automatic logic [16:0] lfsr_next(input logic [16:0] l);
      return {l[15:0], l[16] ^ l[13]};
   endfunction
   function automatic logic [31:0] vexp(input logic lo, input logic hi);
      if (lo)
         return 32'h1;
      return hi ? 32'h3 : 32'h2;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (avs_waitrequest !== 1'b0);
      chk("wait edges", 32'h2, i);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Bounded wait: 0 stop_mode, 1 card_active, 2 presence_ok, else host idle.
   task automatic wait_on(input int w, input logic v);
      logic s;
      for (int i = 0; i < 400; i++) begin
         case (w)
            0: s = stop_mode;
            1: s = card_active;
            2: s = presence_ok;
            default: s = host_idle;
         endcase
         if (s === v)
            break;
         @(posedge sys_clk);
      end
   endtask
   task automatic set_pins(input logic s, input logic lo, input logic hi);
      @(posedge sys_clk);
      want_session <= s;
      want_low <= lo;
      want_high <= hi;
      cyc(2);
      wait_on(3, 1'b1);
   endtask
   task automatic finish_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      cyc(20000);
      n_fail++;
      finish_test();
   end
   initial begin
      cyc(12);
      rstn <= 1'b1;
      bus(1'b0, ADDR_IRQ_MASK, 32'h0);
      chk("irq mask reset", {26'h0, IRQ_MASK_RST}, q);
      bus(1'b1, 4'h2, 32'hFFFFFFFF);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped read", 32'h0, q);
      for (int k = 0; k < 6; k++) begin
         lfsr = lfsr_next(lfsr);
         sel = (k < 3) ? 2'(k) : lfsr[1:0];
         set_pins(1'b0, sel[1], sel[0]);
         cyc(8);
         chk("vcc_level", vexp(sel[1], sel[0]), {30'h0, vcc_level});
      end
      set_pins(1'b0, 1'b0, 1'b0);
      cyc(60);
      bus(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_STOP_ENTER);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      set_pins(1'b0, 1'b1, 1'b1);
      wait_on(0, 1'b1);
      chk("stop_mode", 32'h1, {31'h0, stop_mode});
      cyc(3);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("stop event", 32'h1 << IRQ_STOP_ENTER, q & (32'h1 << IRQ_STOP_ENTER));
      for (int k = 0; k < 4; k++) begin
         lfsr = lfsr_next(lfsr);
         card_present_switch <= lfsr[0];
         cyc(10);
         chk("stop presence", {31'h0, lfsr[0]}, {31'h0, presence_ok});
      end
      chk("irq masked", 32'h0, {31'h0, irq});
      card_present_switch <= 1'b1;
      cyc(10);
      set_pins(1'b0, 1'b0, 1'b1);
      wait_on(0, 1'b0);
      chk("stop exit", 32'h0, {31'h0, stop_mode});
      cyc(PWR / 2);
      chk("wake presence", 32'h0, {31'h0, presence_ok});
      wait_on(2, 1'b1);
      chk("card presence", 32'h1, {31'h0, presence_ok});
      set_pins(1'b1, 1'b0, 1'b1);
      wait_on(1, 1'b1);
      chk("active vcc", {29'h0, 1'b1, VCC_5V0}, {29'h0, vcc_enable, vcc_level});
      set_pins(1'b1, 1'b1, 1'b1);
      cyc(8);
      chk("no stop in session", 32'h2, {30'h0, card_active, stop_mode});
      set_pins(1'b0, 1'b1, 1'b1);
      cyc(5);
      chk("deact first", 32'h0, {30'h0, vcc_enable, stop_mode});
      wait_on(0, 1'b1);
      chk("stop after deact", 32'h1, {31'h0, stop_mode});
      card_present_switch <= 1'b0;
      set_pins(1'b0, 1'b0, 1'b0);
      cyc(DEB + PWR + 20);
      chk("no card presence", 32'h0, {31'h0, presence_ok});
      card_present_switch <= 1'b1;
      set_pins(1'b1, 1'b0, 1'b0);
      wait_on(1, 1'b1);
      bus(1'b1, ADDR_CTRL, 32'h1);
      cyc(2);
      chk("fault presence", 32'h0, {30'h0, card_active, presence_ok});
      set_pins(1'b0, 1'b0, 1'b0);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("fault event", 32'h1 << IRQ_FAULT, q & (32'h1 << IRQ_FAULT));
      bus(1'b1, ADDR_CTRL, 32'h0);
      cyc(DEB);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status state", 32'h1, q & 32'h3F);
      finish_test();
   end
endmodule
